// ==== pcm_pkg.sv ====
package pcm_pkg;

    // Register select codes on the command port
    localparam logic [1:0] PCM_SEL_POWER_RAIL_ENABLE = 2'h0;
    localparam logic [1:0] PCM_SEL_CLOCK_WATCH_ENABLE = 2'h1;
    localparam logic [1:0] PCM_SEL_UNDERVOLTAGE_FLAGS = 2'h2;

    // power_rail_enable fields
    localparam int PCM_PR_EXT_TWO_BIT = 5;
    localparam int PCM_PR_EXT_ONE_BIT = 4;
    localparam int PCM_PR_STEP_UP_BIT = 3;
    localparam int PCM_PR_SECOND_SD_BIT = 1;
    localparam logic [7:0] PCM_PR_RW_MASK = 8'h3A;
    localparam logic [7:0] PCM_PR_KEEP_MASK = 8'h30;
    localparam logic [7:0] PCM_PR_RESET = 8'h0A;

    // clock_watch_enable fields
    localparam int PCM_CW_STEP_UP_BIT = 6;
    localparam int PCM_CW_SECOND_SD_BIT = 4;
    localparam int PCM_CW_FIRST_SD_BIT = 3;
    localparam int PCM_CW_SOURCE_BIT = 2;
    localparam int PCM_CW_SYNC_IN_BIT = 1;
    localparam logic [7:0] PCM_CW_RW_MASK = 8'h5E;
    localparam logic [7:0] PCM_CW_RESET = 8'h5C;

    // undervoltage_flags fields
    localparam int PCM_UV_INPUT_BIT = 6;
    localparam int PCM_UV_INT_REG_BIT = 4;
    localparam int PCM_UV_STEP_UP_BIT = 3;
    localparam int PCM_UV_SECOND_SD_BIT = 1;
    localparam int PCM_UV_FIRST_SD_BIT = 0;
    localparam logic [7:0] PCM_UV_MASK = 8'h5B;
    localparam logic [7:0] PCM_UV_RESET = 8'h00;

    // Initial value of the two external monitor enables
    localparam logic PCM_EXT_EN_RESET = 1'b0;

endpackage

// ==== pcm_regs.sv ====
`timescale 1ns/1ns
// How it works
// - Control registers reset on power-on; RESET entry resets all but the external monitor enables
// - Control writes only while lock bit is clear
// - First step-down on by default, wake controlled
// - Protection may stop first step-down, then restart
// - Bits 5 and 4 enable external monitors
// - External monitor enables survive RESET entry
// - Bit 3 step-up enable, cleared on fault/safe
// - Bit 1 second step-down enable, cleared on fault/safe
// - Clock bits 6,4,3 watch converter clocks, default on
// - Clock bit 2 watches the clock source, default on
// - Clock bit 1 watches sync input, default off
// - Undervoltage flags latch until the register is read
// - Read clears flag only if condition gone
// - Bit 6 input supply undervoltage flag
// - Bits 4,3,1,0 regulator undervoltage flags
// - Undervoltage bits 7,5,2 reserved, read zero
// - Disabled external monitor raises no flags
module pcm_regs
    import pcm_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register command port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [1:0] reg_sel,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata_ff,
    output logic reg_rvalid_ff,
    // Device state and lock
    input wire logic ctrl_lock,
    input wire logic enter_reset_state,
    input wire logic enter_safe_state,
    // Fault shutdowns
    input wire logic step_up_fault_off,
    input wire logic second_step_down_fault_off,
    input wire logic first_step_down_prot_off,
    input wire logic first_step_down_restart_ok,
    // Wake control
    input wire logic wake,
    input wire logic wake_latch,
    // Undervoltage conditions, synchronous
    input wire logic input_supply_low,
    input wire logic internal_regulator_low,
    input wire logic step_up_low,
    input wire logic second_step_down_low,
    input wire logic first_step_down_low,
    // External monitor raw comparators
    input wire logic ext_one_uv_raw,
    input wire logic ext_one_ov_raw,
    input wire logic ext_two_uv_raw,
    input wire logic ext_two_ov_raw,
    // Enables to the analog blocks, undervoltage flags
    output logic first_step_down_on_ff,
    output logic second_step_down_enable_ff,
    output logic step_up_enable_ff,
    output logic ext_monitor_one_enable_ff,
    output logic ext_monitor_two_enable_ff,
    output logic [7:0] clock_watch_enable_ff,
    output logic [7:0] undervoltage_flags_ff,
    // Masked external monitor events
    output logic ext_one_uv_ff,
    output logic ext_one_ov_ff,
    output logic ext_two_uv_ff,
    output logic ext_two_ov_ff
);

    logic prot_off_ff;
    logic [7:0] power_rail_enable;
    logic [7:0] nxt_power_ctrl;
    logic [7:0] nxt_clock_watch;
    logic [7:0] nxt_uv_flags;
    logic [7:0] uv_cond;
    logic [7:0] read_mux;
    logic [7:0] pr_base;
    logic [7:0] cw_base;
    logic nxt_first_on;
    logic nxt_prot_off;
    logic nxt_step_up;
    logic nxt_second_sd;

    // Decoded strobes
    wire wr_ok = reg_wr && !ctrl_lock;
    wire wr_pr = wr_ok && (reg_sel == PCM_SEL_POWER_RAIL_ENABLE);
    wire wr_cw = wr_ok && (reg_sel == PCM_SEL_CLOCK_WATCH_ENABLE);
    wire rd_uv = reg_rd && (reg_sel == PCM_SEL_UNDERVOLTAGE_FLAGS);

    // Writable bits merged over current value
    function automatic logic [7:0] merge(input logic [7:0] cur,
                                         input logic [7:0] wd,
                                         input logic [7:0] msk);
        merge = (cur & ~msk) | (wd & msk);
    endfunction

    // Power register image, reserved bits zero
    assign power_rail_enable = {2'h0,
                                ext_monitor_two_enable_ff,
                                ext_monitor_one_enable_ff,
                                step_up_enable_ff,
                                1'b0,
                                second_step_down_enable_ff,
                                1'b0};

    // RESET entry reinitialises all but external enables
    assign pr_base = enter_reset_state ?
        ((PCM_PR_RESET & ~PCM_PR_KEEP_MASK) |
         (power_rail_enable & PCM_PR_KEEP_MASK)) :
        (wr_pr ? merge(power_rail_enable, reg_wdata, PCM_PR_RW_MASK)
               : power_rail_enable);

    // Faults and SAFE entry clear over writes
    assign nxt_step_up = pr_base[PCM_PR_STEP_UP_BIT] &&
                         !step_up_fault_off &&
                         !enter_safe_state;
    assign nxt_second_sd = pr_base[PCM_PR_SECOND_SD_BIT] &&
                           !second_step_down_fault_off &&
                           !enter_safe_state;
    assign nxt_power_ctrl = {2'h0,
                             pr_base[PCM_PR_EXT_TWO_BIT],
                             pr_base[PCM_PR_EXT_ONE_BIT],
                             nxt_step_up,
                             1'b0,
                             nxt_second_sd,
                             1'b0};

    assign cw_base = wr_cw ?
        merge(clock_watch_enable_ff, reg_wdata, PCM_CW_RW_MASK) :
        clock_watch_enable_ff;
    assign nxt_clock_watch = enter_reset_state ? PCM_CW_RESET
                                               : cw_base;

    // First step-down: wake driven, protection may hold it off
    assign nxt_prot_off = first_step_down_prot_off ? 1'b1 :
        (first_step_down_restart_ok ? 1'b0 : prot_off_ff);
    assign nxt_first_on = (wake || wake_latch) && !nxt_prot_off;

    // Undervoltage condition vector
    assign uv_cond = {1'b0,
                      input_supply_low,
                      1'b0,
                      internal_regulator_low,
                      step_up_low,
                      1'b0,
                      second_step_down_low,
                      first_step_down_low} & PCM_UV_MASK;

    // Set wins; read clears only absent conditions
    assign nxt_uv_flags = uv_cond |
        (undervoltage_flags_ff & ~({8{rd_uv}}));

    assign read_mux = (reg_sel == PCM_SEL_POWER_RAIL_ENABLE) ?
                      power_rail_enable :
                      (reg_sel == PCM_SEL_CLOCK_WATCH_ENABLE) ?
                      clock_watch_enable_ff :
                      (reg_sel == PCM_SEL_UNDERVOLTAGE_FLAGS) ?
                      undervoltage_flags_ff : 8'h00;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_monitor_two_enable_ff <= PCM_EXT_EN_RESET;
            ext_monitor_one_enable_ff <= PCM_EXT_EN_RESET;
            step_up_enable_ff <= PCM_PR_RESET[PCM_PR_STEP_UP_BIT];
            second_step_down_enable_ff <= PCM_PR_RESET[PCM_PR_SECOND_SD_BIT];
            clock_watch_enable_ff <= PCM_CW_RESET;
        end else begin
            ext_monitor_two_enable_ff <= nxt_power_ctrl[PCM_PR_EXT_TWO_BIT];
            ext_monitor_one_enable_ff <= nxt_power_ctrl[PCM_PR_EXT_ONE_BIT];
            step_up_enable_ff <= nxt_power_ctrl[PCM_PR_STEP_UP_BIT];
            second_step_down_enable_ff <=
                nxt_power_ctrl[PCM_PR_SECOND_SD_BIT];
            clock_watch_enable_ff <= nxt_clock_watch;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            undervoltage_flags_ff <= PCM_UV_RESET;
        end else begin
            undervoltage_flags_ff <= nxt_uv_flags;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            prot_off_ff <= 1'b0;
            first_step_down_on_ff <= 1'b0;
        end else begin
            prot_off_ff <= nxt_prot_off;
            first_step_down_on_ff <= nxt_first_on;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata_ff <= 8'h00;
            reg_rvalid_ff <= 1'b0;
        end else begin
            reg_rdata_ff <= reg_rd ? read_mux : reg_rdata_ff;
            reg_rvalid_ff <= reg_rd;
        end
    end

    // External monitor events masked by their enables
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ext_one_uv_ff <= 1'b0;
            ext_one_ov_ff <= 1'b0;
            ext_two_uv_ff <= 1'b0;
            ext_two_ov_ff <= 1'b0;
        end else begin
            ext_one_uv_ff <= ext_one_uv_raw && ext_monitor_one_enable_ff;
            ext_one_ov_ff <= ext_one_ov_raw && ext_monitor_one_enable_ff;
            ext_two_uv_ff <= ext_two_uv_raw && ext_monitor_two_enable_ff;
            ext_two_ov_ff <= ext_two_ov_raw && ext_monitor_two_enable_ff;
        end
    end

    a_locked_write_ignored: assert property (
        @(posedge clk) disable iff (!rst_n)
        (reg_wr && ctrl_lock && !enter_reset_state && !enter_safe_state &&
         !step_up_fault_off && !second_step_down_fault_off)
        |=> $stable(power_rail_enable) && $stable(clock_watch_enable_ff))
        else $error("locked write changed a control register");

    a_write_takes_effect: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wr_cw && !enter_reset_state)
        |=> clock_watch_enable_ff == ($past(reg_wdata) & PCM_CW_RW_MASK))
        else $error("unlocked clock watch write not applied");

    a_reset_entry_init: assert property (
        @(posedge clk) disable iff (!rst_n)
        enter_reset_state |=> clock_watch_enable_ff == PCM_CW_RESET &&
        step_up_enable_ff == !($past(step_up_fault_off) ||
                               $past(enter_safe_state)))
        else $error("RESET entry did not reinitialise controls");

    a_ext_enable_keep: assert property (
        @(posedge clk) disable iff (!rst_n)
        enter_reset_state |=> $stable(ext_monitor_one_enable_ff) &&
                              $stable(ext_monitor_two_enable_ff))
        else $error("external monitor enable changed on RESET entry");

    a_safe_clears_rails: assert property (
        @(posedge clk) disable iff (!rst_n)
        enter_safe_state |=> !step_up_enable_ff &&
                             !second_step_down_enable_ff)
        else $error("SAFE entry left a rail enabled");

    a_fault_clears_sd2: assert property (
        @(posedge clk) disable iff (!rst_n)
        second_step_down_fault_off |=> !second_step_down_enable_ff)
        else $error("second step-down fault did not clear enable");

    a_reserved_zero: assert property (
        @(posedge clk) disable iff (!rst_n)
        power_rail_enable[7:6] == 2'h0 &&
        (undervoltage_flags_ff & ~PCM_UV_MASK) == 8'h00 &&
        (clock_watch_enable_ff & ~PCM_CW_RW_MASK) == 8'h00)
        else $error("reserved bit reads nonzero");

    a_flag_held_til_read: assert property (
        @(posedge clk) disable iff (!rst_n)
        (undervoltage_flags_ff[PCM_UV_INPUT_BIT] && !rd_uv)
        |=> undervoltage_flags_ff[PCM_UV_INPUT_BIT])
        else $error("undervoltage flag dropped without read");

    a_read_clears_gone: assert property (
        @(posedge clk) disable iff (!rst_n)
        (rd_uv && !first_step_down_low)
        |=> !undervoltage_flags_ff[PCM_UV_FIRST_SD_BIT])
        else $error("read did not clear absent condition");

    a_set_beats_clear: assert property (
        @(posedge clk) disable iff (!rst_n)
        (rd_uv && step_up_low)
        |=> undervoltage_flags_ff[PCM_UV_STEP_UP_BIT])
        else $error("set lost against clearing read");

    a_ext_mask: assert property (
        @(posedge clk) disable iff (!rst_n)
        !ext_monitor_one_enable_ff |=> !ext_one_uv_ff && !ext_one_ov_ff)
        else $error("disabled external monitor raised event");

    a_first_sd_prot: assert property (
        @(posedge clk) disable iff (!rst_n)
        first_step_down_prot_off |=> !first_step_down_on_ff)
        else $error("first step-down stayed on under protection");

    a_first_sd_restart: assert property (
        @(posedge clk) disable iff (!rst_n)
        (first_step_down_restart_ok && !first_step_down_prot_off &&
         wake) |=> first_step_down_on_ff)
        else $error("first step-down did not restart with wake");

    a_read_answer: assert property (
        @(posedge clk) disable iff (!rst_n)
        (reg_rd && reg_sel == PCM_SEL_CLOCK_WATCH_ENABLE)
        |=> reg_rvalid_ff && reg_rdata_ff == $past(clock_watch_enable_ff))
        else $error("clock watch read returned wrong data");

    a_rvalid_one_cycle: assert property (
        @(posedge clk) disable iff (!rst_n)
        !reg_rd |=> !reg_rvalid_ff)
        else $error("read answer without a read");

    a_fault_clears_su: assert property (
        @(posedge clk) disable iff (!rst_n)
        step_up_fault_off |=> !step_up_enable_ff)
        else $error("step-up fault did not clear enable");

    a_ext_enable_write: assert property (
        @(posedge clk) disable iff (!rst_n)
        (wr_pr && !enter_reset_state) |=>
        ext_monitor_two_enable_ff == $past(reg_wdata[PCM_PR_EXT_TWO_BIT]) &&
        ext_monitor_one_enable_ff == $past(reg_wdata[PCM_PR_EXT_ONE_BIT]))
        else $error("external monitor enable write not applied");

    a_reset_entry_sd2: assert property (
        @(posedge clk) disable iff (!rst_n)
        (enter_reset_state && !second_step_down_fault_off &&
         !enter_safe_state) |=> second_step_down_enable_ff)
        else $error("RESET entry did not restore second step-down");

    a_input_low_set: assert property (
        @(posedge clk) disable iff (!rst_n)
        input_supply_low |=> undervoltage_flags_ff[PCM_UV_INPUT_BIT])
        else $error("input supply undervoltage not latched");

    a_sd2_low_set: assert property (
        @(posedge clk) disable iff (!rst_n)
        second_step_down_low |=> undervoltage_flags_ff[PCM_UV_SECOND_SD_BIT])
        else $error("second step-down undervoltage not latched");

    a_flags_held_all: assert property (
        @(posedge clk) disable iff (!rst_n)
        !rd_uv |=> (undervoltage_flags_ff & $past(undervoltage_flags_ff)) ==
                   $past(undervoltage_flags_ff))
        else $error("a latched flag dropped without a read");

    a_first_sd_off: assert property (
        @(posedge clk) disable iff (!rst_n)
        (!wake && !wake_latch) |=> !first_step_down_on_ff)
        else $error("first step-down on without wake");

    a_ext_two_mask: assert property (
        @(posedge clk) disable iff (!rst_n)
        !ext_monitor_two_enable_ff |=> !ext_two_uv_ff && !ext_two_ov_ff)
        else $error("disabled second external monitor raised event");

endmodule

// ==== pcm_host_model.sv ====
`timescale 1ns/1ns
module pcm_host_model
    import pcm_pkg::*;
(
    // Clock
    input wire logic clk,
    // Register command port
    output logic reg_wr,
    output logic reg_rd,
    output logic [1:0] reg_sel,
    output logic [7:0] reg_wdata,
    input wire logic [7:0] reg_rdata_ff,
    input wire logic reg_rvalid_ff
);
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_sel = 2'h3;
        reg_wdata = 8'hA5;
    end

    // Idle lines flip so stale values never look valid
    task automatic release_bus();
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_sel = ~reg_sel;
        reg_wdata = ~reg_wdata;
    endtask

    task automatic wr(input logic [1:0] sel, input logic [7:0] d);
        @(posedge clk);
        #1;
        reg_sel = sel;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(posedge clk);
        #1;
        release_bus();
    endtask

    // Answer is registered on the edge that takes the read
    task automatic rd(input logic [1:0] sel, output logic [7:0] d,
                      output bit ok);
        @(posedge clk);
        #1;
        reg_sel = sel;
        reg_rd = 1'b1;
        @(posedge clk);
        #1;
        ok = (reg_rvalid_ff === 1'b1);
        d = reg_rdata_ff;
        release_bus();
    endtask
endmodule

// ==== test_power_clock_monitor_ctrl_regs.sv ====
`timescale 1ns/1ns
module test_power_clock_monitor_ctrl_regs
    import pcm_pkg::*;
;
    typedef struct packed {
        logic [1:0] sel;
        logic [7:0] wd;
        logic [7:0] exp;
    } pcm_row_s;

    logic clk, rst_n, ctrl_lock, wake, wake_latch, reg_wr, reg_rd;
    logic [5:0] ev;
    logic [4:0] lows;
    logic [3:0] raw;
    logic [1:0] reg_sel;
    logic [7:0] reg_wdata, reg_rdata_ff;
    logic [7:0] clock_watch_enable_ff, undervoltage_flags_ff;
    logic reg_rvalid_ff, first_step_down_on_ff, second_step_down_enable_ff;
    logic step_up_enable_ff, ext_monitor_one_enable_ff;
    logic ext_monitor_two_enable_ff, ext_one_uv_ff, ext_one_ov_ff;
    logic ext_two_uv_ff, ext_two_ov_ff;
    int n_errors, num_checks;
    wire logic enter_reset_state = ev[0];
    wire logic enter_safe_state = ev[1];
    wire logic step_up_fault_off = ev[2];
    wire logic second_step_down_fault_off = ev[3];
    wire logic first_step_down_prot_off = ev[4];
    wire logic first_step_down_restart_ok = ev[5];
    wire logic input_supply_low = lows[4];
    wire logic internal_regulator_low = lows[3];
    wire logic step_up_low = lows[2];
    wire logic second_step_down_low = lows[1];
    wire logic first_step_down_low = lows[0];
    wire logic ext_one_uv_raw = raw[0];
    wire logic ext_one_ov_raw = raw[1];
    wire logic ext_two_uv_raw = raw[2];
    wire logic ext_two_ov_raw = raw[3];
    wire logic [3:0] pr_outs = {ext_monitor_two_enable_ff,
        ext_monitor_one_enable_ff, step_up_enable_ff,
        second_step_down_enable_ff};
    wire logic [3:0] ext_outs = {ext_two_ov_ff, ext_two_uv_ff,
        ext_one_ov_ff, ext_one_uv_ff};
    pcm_row_s rows [8] = '{'{2'h0, 8'hFF, 8'h3A}, '{2'h0, 8'h00, 8'h00},
        '{2'h0, 8'h10, 8'h10}, '{2'h1, 8'hFF, 8'h5E},
        '{2'h1, 8'h00, 8'h00}, '{2'h1, 8'h02, 8'h02},
        '{2'h2, 8'hFF, 8'h00}, '{2'h3, 8'hFF, 8'h00}};

    pcm_regs uut (
        .clk, .rst_n, .reg_wr, .reg_rd, .reg_sel, .reg_wdata, .reg_rdata_ff,
        .reg_rvalid_ff, .ctrl_lock, .enter_reset_state, .enter_safe_state,
        .step_up_fault_off, .second_step_down_fault_off,
        .first_step_down_prot_off, .first_step_down_restart_ok, .wake,
        .wake_latch, .input_supply_low, .internal_regulator_low,
        .step_up_low, .second_step_down_low, .first_step_down_low,
        .ext_one_uv_raw, .ext_one_ov_raw, .ext_two_uv_raw, .ext_two_ov_raw,
        .first_step_down_on_ff, .second_step_down_enable_ff,
        .step_up_enable_ff, .ext_monitor_one_enable_ff,
        .ext_monitor_two_enable_ff, .clock_watch_enable_ff,
        .undervoltage_flags_ff, .ext_one_uv_ff, .ext_one_ov_ff,
        .ext_two_uv_ff, .ext_two_ov_ff
    );
    pcm_host_model host (
        .clk, .reg_wr, .reg_rd, .reg_sel, .reg_wdata, .reg_rdata_ff,
        .reg_rvalid_ff
    );

    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    task automatic stop_test();
        $display("n_errors %0d num_checks %0d", n_errors, num_checks);
        if (n_errors == 0 && num_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic rdc(input logic [1:0] s, input logic [7:0] e);
        logic [7:0] d;
        bit ok;
        host.rd(s, d, ok);
        if (!ok) begin
            n_errors++;
            $display("BAD %0t no read answer", $time);
            stop_test();
        end
        chk(d, e);
    endtask

    task automatic pulse(input int i);
        @(posedge clk);
        #1 ev[i] = 1'b1;
        @(posedge clk);
        #1 ev[i] = 1'b0;
    endtask

    task automatic settle();
        repeat (2) @(posedge clk);
        #1;
    endtask

    initial begin
        rst_n = 1'b0;
        {ctrl_lock, wake_latch, ev, lows, raw} = '0;
        wake = 1'b1;
        repeat (10) @(posedge clk);
        #1 rst_n = 1'b1;
        rdc(2'h0, 8'h0A);
        rdc(2'h1, 8'h5C);
        rdc(2'h2, 8'h00);
        chk({7'h0, first_step_down_on_ff}, 8'h01);
        pulse(4);
        settle();
        chk({7'h0, first_step_down_on_ff}, 8'h00);
        pulse(5);
        settle();
        chk({7'h0, first_step_down_on_ff}, 8'h01);
        wake = 1'b0;
        wake_latch = 1'b1;
        settle();
        chk({7'h0, first_step_down_on_ff}, 8'h01);
        wake_latch = 1'b0;
        settle();
        chk({7'h0, first_step_down_on_ff}, 8'h00);
        wake = 1'b1;
        foreach (rows[i]) begin
            host.wr(rows[i].sel, rows[i].wd);
            rdc(rows[i].sel, rows[i].exp);
            if (rows[i].sel == 2'h0) begin
                chk({4'h0, pr_outs}, {4'h0, rows[i].exp[5:3],
                    rows[i].exp[1]});
            end
            if (rows[i].sel == 2'h1) begin
                chk(clock_watch_enable_ff, rows[i].exp);
            end
        end
        ctrl_lock = 1'b1;
        host.wr(2'h0, 8'h00);
        host.wr(2'h1, 8'hFF);
        rdc(2'h0, 8'h10);
        rdc(2'h1, 8'h02);
        ctrl_lock = 1'b0;
        pulse(0);
        rdc(2'h0, 8'h1A);
        rdc(2'h1, 8'h5C);
        host.wr(2'h0, 8'h3A);
        pulse(2);
        rdc(2'h0, 8'h32);
        pulse(3);
        rdc(2'h0, 8'h30);
        host.wr(2'h0, 8'h3A);
        pulse(1);
        rdc(2'h0, 8'h30);
        chk({4'h0, pr_outs}, 8'h0C);
        host.wr(2'h0, 8'h00);
        raw = 4'hF;
        settle();
        chk({4'h0, ext_outs}, 8'h00);
        host.wr(2'h0, 8'h30);
        settle();
        chk({4'h0, ext_outs}, 8'h0F);
        raw = 4'h0;
        lows = 5'h1F;
        @(posedge clk);
        #1 lows = 5'h00;
        settle();
        chk(undervoltage_flags_ff, 8'h5B);
        rdc(2'h2, 8'h5B);
        rdc(2'h2, 8'h00);
        lows[4] = 1'b1;
        rdc(2'h2, 8'h40);
        rdc(2'h2, 8'h40);
        lows[4] = 1'b0;
        rdc(2'h2, 8'h40);
        rdc(2'h2, 8'h00);
        fork
            rdc(2'h2, 8'h00);
            begin
                @(posedge clk);
                #1 lows[2] = 1'b1;
                @(posedge clk);
                #1 lows[2] = 1'b0;
            end
        join
        rdc(2'h2, 8'h08);
        // Power-on reset in mid-run
        host.wr(2'h1, 8'h00);
        @(posedge clk);
        #1 rst_n = 1'b0;
        @(posedge clk);
        #1;
        chk({4'h0, pr_outs}, 8'h03);
        chk(clock_watch_enable_ff, 8'h5C);
        repeat (2) @(posedge clk);
        #1 rst_n = 1'b1;
        rdc(2'h0, 8'h0A);
        rdc(2'h1, 8'h5C);
        @(posedge clk);
        #1;
        chk({7'h0, reg_rvalid_ff}, 8'h00);
        chk(reg_rdata_ff, 8'h5C);
        stop_test();
    end
endmodule
